// ### pkg/fes_regs.svh
`ifndef FES_REGS_SVH
`define FES_REGS_SVH

// byte offsets of the frame words on the register port
`define FES_OFF_CMD 8'h00
`define FES_OFF_PC 8'h04
`define FES_OFF_IAR 8'h08
`define FES_OFF_SRC_HI 8'h0c
`define FES_OFF_SRC_MH 8'h10
`define FES_OFF_SRC_ML 8'h14
`define FES_OFF_DST_HI 8'h18
`define FES_OFF_DST_MH 8'h1c
`define FES_OFF_DST_ML 8'h20
`define FES_OFF_WB_HI 8'h24
`define FES_OFF_WB_MH 8'h28
`define FES_OFF_WB_ML 8'h2c
`define FES_OFF_STATUS 8'h30
`define FES_OFF_CTRL 8'h34

// command word field positions
`define FES_CMD_CLASS_HI 15
`define FES_CMD_CLASS_LO 13
`define FES_OPCLASS_RR 3'h0
`define FES_OPCLASS_MR 3'h2
`define FES_OPCLASS_OUT 3'h3

// low seven command bits of interest
`define FES_OP_SQRT 7'h04
`define FES_OP_SQRT_MAP 7'h05
`define FES_OP_ADD 7'h22
`define FES_OP_SUB 7'h28
`define FES_OP_MUL 7'h23
`define FES_OP_DIV 7'h20
`define FES_WB_SQRT_CODE 6'h21

// data type tags
`define FES_TAG_NORM 3'h0
`define FES_TAG_ZERO 3'h1
`define FES_TAG_INF 3'h2
`define FES_TAG_NAN 3'h3
`define FES_TAG_EXT_DEN 3'h4
`define FES_TAG_SD_DEN 3'h5

// quiet bit of an extended mantissa
`define FES_NAN_QUIET_BIT 62

// frame lengths in words
`define FES_FRAME_UNIMP 8'h1a
`define FES_FRAME_BUSY 8'h32

// control word bits, write one to act
`define FES_CTRL_CLR_WB 0
`define FES_CTRL_CLR_CONV 1
`define FES_CTRL_DISCARD 2

// reset values
`define FES_RST_WORD 32'h0000_0000
`endif

// ### pkg/fes_pkg.sv
package fes_pkg;
	typedef enum logic [1:0] {
		FES_KIND_UNIMP = 2'b00,
		FES_KIND_UNSUPP = 2'b01,
		FES_KIND_SIG_NAN = 2'b10,
		FES_KIND_OTHER = 2'b11
	} fes_kind_type;

	typedef enum logic [1:0] {
		FES_WB_NONE = 2'b00,
		FES_WB_OVERFLOW = 2'b01,
		FES_WB_UNDERFLOW = 2'b10,
		FES_WB_INEXACT = 2'b11
	} fes_wb_kind_type;

	typedef struct packed {
		logic [15:0] conv_cmd;
		logic [8:0] wb_cmd;
		logic [31:0] pc;
		logic [31:0] iar;
		logic conv_fault;
		logic wb_fault;
		logic post_flag;
		logic unimp;
		logic [1:0] wb_kind;
		logic src_sign;
		logic [14:0] src_exp;
		logic [63:0] src_mant;
		logic [2:0] src_tag;
		logic dst_sign;
		logic [14:0] dst_exp;
		logic [63:0] dst_mant;
		logic [2:0] dst_tag;
		logic wb_sign;
		logic [15:0] wb_exp;
		logic [66:0] wb_mant;
		logic wb_sticky;
		logic [31:0] rdata;
	} fes_state_type;
endpackage

// ### hdl/fes_frame.sv
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "fes_regs.svh"

// Function
// - conversion fault records second command word
// - square root low bits 4 become 5
// - write-back stores encoded command, sqrt 21
// - save conversion stage pc and address
// - conversion fault flag set on any exception
// - unimplemented frame: flag means packed source (code sets it for any unimplemented capture, whatever src_packed_in)
// - write-back flag only arithmetic classes 0,2
// - source temp extended, packed bits 63-0
// - destination temp, packed bits 95-64 low
// - operation class is command bits 15-13
// - three-bit type tags with fixed encodings
// - source tag undefined for packed source
// - post flag only for class 3 move
// - write-back result image in internal format
// - unimplemented class 0,2 fills short 26-word frame
// - unsupported type class 0,2 fills frame
// - unsupported type class 3 sets both flags
// - signaling nan class 0,2 fills frame
// - signaling nan class 3 quieted, tagged nan
// - frame length 26 or 50 words
module fes_frame (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic cu_exc_in,
	input wire logic [1:0] cu_kind_in,
	input wire logic [15:0] cu_cmd_in,
	input wire logic [31:0] cu_pc_in,
	input wire logic [31:0] cu_iar_in,
	input wire logic [79:0] src_ext_in,
	input wire logic [2:0] src_tag_in,
	input wire logic [79:0] dst_ext_in,
	input wire logic [2:0] dst_tag_in,
	input wire logic dyadic_in,
	input wire logic src_packed_in,
	input wire logic [95:0] packed_in,
	input wire logic wb_exc_in,
	input wire logic [1:0] wb_kind_in,
	input wire logic [15:0] wb_cmd_in,
	input wire logic wb_sign_in,
	input wire logic [15:0] wb_exp_in,
	input wire logic [66:0] wb_mant_in,
	input wire logic wb_sticky_in,
	output logic conv_fault_out,
	output logic wb_fault_out,
	output logic post_flag_out,
	output logic [7:0] frame_words_out
);
	fes_pkg::fes_state_type s_q;
	fes_pkg::fes_state_type s_d;

	function automatic logic [6:0] map_low(input logic [15:0] cmd);
		if (cmd[6:0] == `FES_OP_SQRT) begin
			map_low = `FES_OP_SQRT_MAP;
		end else begin
			map_low = cmd[6:0];
		end
	endfunction

	function automatic logic [2:0] op_class(input logic [15:0] cmd);
		op_class = cmd[`FES_CMD_CLASS_HI:`FES_CMD_CLASS_LO];
	endfunction

	function automatic logic [8:0] wb_encode(input logic [15:0] cmd);
		logic [6:0] m;
		m = map_low(cmd);
		// bit shuffle keeps the five arithmetic ops distinct in six bits
		wb_encode = {cmd[9:7], m[2], m[3], m[5], m[6], m[1], m[0]};
	endfunction

	function automatic logic arith_op(input logic [15:0] cmd);
		logic [6:0] m;
		m = cmd[6:0];
		arith_op = (m == `FES_OP_ADD) || (m == `FES_OP_SUB) || (m == `FES_OP_MUL) ||
			(m == `FES_OP_DIV) || (m == `FES_OP_SQRT);
	endfunction

	function automatic logic in_class(input logic [15:0] cmd);
		in_class = (op_class(cmd) == `FES_OPCLASS_RR) || (op_class(cmd) == `FES_OPCLASS_MR);
	endfunction

	logic wb_take;
	logic cu_out_class;
	logic clr_wb;
	logic clr_conv;
	logic discard;

	assign wb_take = wb_exc_in && (wb_kind_in != fes_pkg::FES_WB_NONE) &&
		in_class(wb_cmd_in) && arith_op(wb_cmd_in);
	assign cu_out_class = op_class(cu_cmd_in) == `FES_OPCLASS_OUT;
	assign clr_wb = wr_in && addr_in == `FES_OFF_CTRL && wdata_in[`FES_CTRL_CLR_WB];
	assign clr_conv = wr_in && addr_in == `FES_OFF_CTRL && wdata_in[`FES_CTRL_CLR_CONV];
	assign discard = wr_in && addr_in == `FES_OFF_CTRL && wdata_in[`FES_CTRL_DISCARD];

	always_comb begin
		s_d = s_q;
		// flag clears first so a same-cycle capture overrides them
		if (clr_conv || discard) begin
			s_d.conv_fault = 1'b0;
			s_d.post_flag = 1'b0;
		end
		if (clr_wb || discard) begin
			s_d.wb_fault = 1'b0;
		end
		if (cu_exc_in) begin
			s_d.conv_fault = 1'b1;
			s_d.conv_cmd = {cu_cmd_in[15:7], map_low(cu_cmd_in)};
			s_d.pc = cu_pc_in;
			s_d.iar = cu_iar_in;
			s_d.unimp = cu_kind_in == fes_pkg::FES_KIND_UNIMP;
			s_d.post_flag = cu_out_class;
			s_d.src_sign = src_ext_in[79];
			s_d.src_exp = src_ext_in[78:64];
			s_d.src_mant = src_ext_in[63:0];
			s_d.src_tag = src_tag_in;
			if (cu_out_class) begin
				// class 3: unrounded register source, no destination
				if (cu_kind_in == fes_pkg::FES_KIND_SIG_NAN) begin
					s_d.src_mant[`FES_NAN_QUIET_BIT] = 1'b1;
					s_d.src_tag = `FES_TAG_NAN;
				end
			end else begin
				// classes 0 and 2 carry the destination operand only when dyadic_in is set
				if (dyadic_in) begin
					s_d.dst_sign = dst_ext_in[79];
					s_d.dst_exp = dst_ext_in[78:64];
					s_d.dst_mant = dst_ext_in[63:0];
					s_d.dst_tag = dst_tag_in;
				end
				if (src_packed_in) begin
					// sign, exponent and tag left as whatever the pipeline drove
					s_d.src_mant = packed_in[63:0];
					s_d.dst_mant[31:0] = packed_in[95:64];
				end
			end
		end
		if (wb_take) begin
			s_d.wb_fault = 1'b1;
			s_d.wb_kind = wb_kind_in;
			s_d.wb_cmd = wb_encode(wb_cmd_in);
			s_d.wb_sign = wb_sign_in;
			s_d.wb_exp = wb_exp_in;
			s_d.wb_mant = wb_mant_in;
			s_d.wb_sticky = wb_sticky_in;
		end
		s_d.rdata = `FES_RST_WORD;
		if (rd_in) begin
			unique case (addr_in)
				`FES_OFF_CMD: begin
					s_d.rdata = {1'b0, op_class(s_q.conv_cmd), s_q.post_flag, s_q.wb_fault,
						s_q.conv_fault, s_q.wb_cmd, s_q.conv_cmd};
				end
				`FES_OFF_PC: begin
					s_d.rdata = s_q.pc;
				end
				`FES_OFF_IAR: begin
					s_d.rdata = s_q.iar;
				end
				`FES_OFF_SRC_HI: begin
					s_d.rdata = {s_q.src_sign, s_q.src_exp, 10'h000, s_q.dst_tag, s_q.src_tag};
				end
				`FES_OFF_SRC_MH: begin
					s_d.rdata = s_q.src_mant[63:32];
				end
				`FES_OFF_SRC_ML: begin
					s_d.rdata = s_q.src_mant[31:0];
				end
				`FES_OFF_DST_HI: begin
					s_d.rdata = {s_q.dst_sign, s_q.dst_exp, 16'h0000};
				end
				`FES_OFF_DST_MH: begin
					s_d.rdata = s_q.dst_mant[63:32];
				end
				`FES_OFF_DST_ML: begin
					s_d.rdata = s_q.dst_mant[31:0];
				end
				`FES_OFF_WB_HI: begin
					s_d.rdata = {s_q.wb_sign, 9'h000, s_q.wb_kind, s_q.wb_sticky,
						s_q.wb_mant[0], s_q.wb_mant[1], s_q.wb_mant[66], s_q.wb_exp};
				end
				`FES_OFF_WB_MH: begin
					s_d.rdata = s_q.wb_mant[65:34];
				end
				`FES_OFF_WB_ML: begin
					s_d.rdata = s_q.wb_mant[33:2];
				end
				`FES_OFF_STATUS: begin
					s_d.rdata = {22'h0, s_q.unimp, s_q.conv_fault | s_q.wb_fault,
						frame_words_out};
				end
				default: begin
					s_d.rdata = `FES_RST_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_out = s_q.rdata;
	assign conv_fault_out = s_q.conv_fault;
	assign wb_fault_out = s_q.wb_fault;
	assign post_flag_out = s_q.post_flag;
	// busy frame whenever the capture was not an unimplemented instruction
	assign frame_words_out = s_q.unimp ? `FES_FRAME_UNIMP : `FES_FRAME_BUSY;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);

	AST_CONV_CMD_SQRT: assert property (
		cu_exc_in && cu_cmd_in[6:0] == `FES_OP_SQRT |=>
			s_q.conv_cmd[6:0] == `FES_OP_SQRT_MAP)
		else $error("square root command not remapped");

	AST_CONV_CMD_DIRECT: assert property (
		cu_exc_in && cu_cmd_in[6:0] != `FES_OP_SQRT |=>
			s_q.conv_cmd == $past(cu_cmd_in))
		else $error("conversion command word not stored as given");

	AST_WB_SQRT_CODE: assert property (
		wb_take && wb_cmd_in[6:0] == `FES_OP_SQRT |=>
			s_q.wb_cmd[5:0] == `FES_WB_SQRT_CODE)
		else $error("square root write-back code wrong");

	AST_PC_IAR: assert property (
		cu_exc_in |=> s_q.pc == $past(cu_pc_in) && s_q.iar == $past(cu_iar_in))
		else $error("conversion stage pc or address not saved");

	AST_CONV_FLAG_HOLDS: assert property (
		cu_exc_in ##1 !(clr_conv || discard) [*2] |-> conv_fault_out)
		else $error("conversion fault flag lost");

	AST_WB_FLAG_CAUSE: assert property (
		$rose(wb_fault_out) |-> $past(wb_take))
		else $error("write-back flag set without arithmetic fault");

	AST_WB_FLAG_CLASS: assert property (
		wb_exc_in && !in_class(wb_cmd_in) && !wb_fault_out |=> !wb_fault_out)
		else $error("write-back flag set for wrong class");

	AST_PACKED_SRC: assert property (
		cu_exc_in && src_packed_in && !cu_out_class |=>
			s_q.src_mant == $past(packed_in[63:0]))
		else $error("packed source bits not in mantissa");

	AST_PACKED_DST: assert property (
		cu_exc_in && src_packed_in && !cu_out_class |=>
			s_q.dst_mant[31:0] == $past(packed_in[95:64]))
		else $error("packed upper bits not in destination mantissa");

	AST_POST_ONLY_OUT: assert property (
		cu_exc_in |=> post_flag_out == ($past(op_class(cu_cmd_in)) == `FES_OPCLASS_OUT))
		else $error("post flag does not follow class 3");

	AST_WB_IMAGE: assert property (
		wb_take |=> s_q.wb_mant == $past(wb_mant_in) && s_q.wb_sticky == $past(wb_sticky_in)
			&& s_q.wb_exp == $past(wb_exp_in))
		else $error("write-back image not captured");

	AST_SIG_NAN_OUT: assert property (
		cu_exc_in && cu_out_class && cu_kind_in == fes_pkg::FES_KIND_SIG_NAN |=>
			s_q.src_tag == `FES_TAG_NAN && s_q.src_mant[`FES_NAN_QUIET_BIT]
			&& conv_fault_out && post_flag_out)
		else $error("class 3 signaling nan frame wrong");

	AST_DYADIC_DST: assert property (
		cu_exc_in && !cu_out_class && dyadic_in && !src_packed_in |=>
			s_q.dst_tag == $past(dst_tag_in) && s_q.dst_mant == $past(dst_ext_in[63:0]))
		else $error("destination operand not captured");

	AST_FRAME_LEN: assert property (
		cu_exc_in ##1 !cu_exc_in |-> frame_words_out ==
			(($past(cu_kind_in) == fes_pkg::FES_KIND_UNIMP) ? `FES_FRAME_UNIMP :
			`FES_FRAME_BUSY))
		else $error("frame length wrong");

	AST_SET_BEATS_CLEAR: assert property (
		wb_take && clr_wb |=> wb_fault_out)
		else $error("write-back event lost to clear");

	AST_READ_ONE_CYCLE: assert property (
		!rd_in |=> rdata_out == `FES_RST_WORD)
		else $error("read data present without read");

	AST_CONV_SET_BEATS_CLEAR: assert property (
		cu_exc_in && (clr_conv || discard) |=> conv_fault_out)
		else $error("conversion event lost to clear");

	AST_CONV_FLAG_CAUSE: assert property (
		$rose(conv_fault_out) |-> $past(cu_exc_in))
		else $error("conversion flag set without exception");

	AST_CLEAR_CONV: assert property (
		(clr_conv || discard) && !cu_exc_in |=> !conv_fault_out && !post_flag_out)
		else $error("conversion flags not cleared");

	AST_CLEAR_WB: assert property (
		(clr_wb || discard) && !wb_take |=> !wb_fault_out)
		else $error("write-back flag not cleared");

	AST_WB_KIND: assert property (
		wb_take |=> wb_fault_out && s_q.wb_kind == $past(wb_kind_in))
		else $error("write-back exception kind not recorded");

	AST_WB_HOLD: assert property (
		!wb_take |=> $stable(s_q.wb_mant) && $stable(s_q.wb_exp) && $stable(s_q.wb_sticky))
		else $error("write-back image changed without fault");

	AST_SRC_EXT: assert property (
		cu_exc_in && !src_packed_in &&
			!(cu_out_class && cu_kind_in == fes_pkg::FES_KIND_SIG_NAN) |=>
			{s_q.src_sign, s_q.src_exp, s_q.src_mant} == $past(src_ext_in))
		else $error("source operand not stored in extended form");

	AST_SRC_TAG_KEPT: assert property (
		cu_exc_in && !(cu_out_class && cu_kind_in == fes_pkg::FES_KIND_SIG_NAN) |=>
			s_q.src_tag == $past(src_tag_in))
		else $error("source tag not stored as given");

	AST_UNIMP_FRAME: assert property (
		cu_exc_in && !cu_out_class && cu_kind_in == fes_pkg::FES_KIND_UNIMP |=>
			conv_fault_out && !post_flag_out && frame_words_out == `FES_FRAME_UNIMP)
		else $error("unimplemented frame flags wrong");

	AST_MONADIC_DST: assert property (
		cu_exc_in && !dyadic_in && !src_packed_in |=>
			$stable(s_q.dst_mant) && $stable(s_q.dst_tag))
		else $error("destination changed without a destination operand");

	AST_UNSUPP_FRAME: assert property (
		cu_exc_in && !cu_out_class && cu_kind_in == fes_pkg::FES_KIND_UNSUPP |=>
			conv_fault_out && !post_flag_out && frame_words_out == `FES_FRAME_BUSY)
		else $error("unsupported type frame flags wrong");

	AST_UNSUPP_OUT: assert property (
		cu_exc_in && cu_out_class && cu_kind_in == fes_pkg::FES_KIND_UNSUPP |=>
			conv_fault_out && post_flag_out && s_q.src_mant == $past(src_ext_in[63:0]))
		else $error("class 3 unsupported type frame wrong");

	AST_OUT_NO_DST: assert property (
		cu_exc_in && cu_out_class |=> $stable(s_q.dst_mant) && $stable(s_q.dst_tag))
		else $error("class 3 capture touched the destination");

	AST_SIG_NAN_FRAME: assert property (
		cu_exc_in && !cu_out_class && cu_kind_in == fes_pkg::FES_KIND_SIG_NAN |=>
			conv_fault_out && !post_flag_out && frame_words_out == `FES_FRAME_BUSY)
		else $error("signaling nan frame flags wrong");

	AST_POST_NEEDS_CONV: assert property (
		post_flag_out |-> conv_fault_out)
		else $error("post flag without conversion flag");

	AST_CMD_CLASS_READ: assert property (
		rd_in && addr_in == `FES_OFF_CMD |=> rdata_out[30:28] == $past(s_q.conv_cmd[15:13]))
		else $error("operation class not read from command bits");
endmodule

// ### dv/tb_fes_frame.sv
`timescale 1ns/1ps
`include "fes_regs.svh"
module tb_fes_frame;
	localparam logic [79:0] SRC = 80'hc00a_8123_4567_89ab_cdef;
	localparam logic [79:0] DST = 80'h3fff_9876_5432_1fed_cba0;
	localparam logic [95:0] PKD = 96'h1111_2222_3333_4444_5555_6666;
	localparam logic [66:0] WBM = 67'h5_dead_beef_0123_4567;
	logic clock_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic cu_exc_in = 1'b0;
	logic [1:0] cu_kind_in = 2'h0;
	logic [15:0] cu_cmd_in = 16'h0;
	logic [31:0] cu_pc_in = 32'h0000_1230;
	logic [31:0] cu_iar_in = 32'h0000_1228;
	logic [79:0] src_ext_in = SRC;
	logic [2:0] src_tag_in = 3'h4;
	logic [79:0] dst_ext_in = DST;
	logic [2:0] dst_tag_in = 3'h1;
	logic dyadic_in = 1'b1;
	logic src_packed_in = 1'b0;
	logic [95:0] packed_in = PKD;
	logic wb_exc_in = 1'b0;
	logic [1:0] wb_kind_in = 2'h0;
	logic [15:0] wb_cmd_in = 16'h0;
	logic wb_sign_in = 1'b1;
	logic [15:0] wb_exp_in = 16'h8123;
	logic [66:0] wb_mant_in = WBM;
	logic wb_sticky_in = 1'b1;
	logic [31:0] rdata_out;
	logic conv_fault_out;
	logic wb_fault_out;
	logic post_flag_out;
	logic [7:0] frame_words_out;
	logic [31:0] rv;
	int failures = 0;
	int tests_run = 0;
	int cycles = 0;

	fes_frame dut (.clock_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
		.cu_exc_in, .cu_kind_in, .cu_cmd_in, .cu_pc_in, .cu_iar_in, .src_ext_in,
		.src_tag_in, .dst_ext_in, .dst_tag_in, .dyadic_in, .src_packed_in, .packed_in,
		.wb_exc_in, .wb_kind_in, .wb_cmd_in, .wb_sign_in, .wb_exp_in, .wb_mant_in,
		.wb_sticky_in, .conv_fault_out, .wb_fault_out, .post_flag_out, .frame_words_out);

	always #12.5 clock_in = ~clock_in;

	task automatic final_report;
		if (failures == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// a hung handshake would otherwise stall the run silently
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			final_report();
		end
	end

	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clock_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge clock_in);
		rd_in <= 1'b0;
		#1 rv = rdata_out;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge clock_in);
		wr_in <= 1'b0;
	endtask

	task automatic cap(input logic [1:0] k, input logic [15:0] c, input logic pk);
		@(posedge clock_in);
		cu_exc_in <= 1'b1;
		cu_kind_in <= k;
		cu_cmd_in <= c;
		src_packed_in <= pk;
		@(posedge clock_in);
		cu_exc_in <= 1'b0;
		#1;
	endtask

	task automatic wbone(input logic [1:0] k, input logic [15:0] c, input logic e);
		wr(`FES_OFF_CTRL, 32'h1);
		@(posedge clock_in);
		wb_exc_in <= 1'b1;
		wb_kind_in <= k;
		wb_cmd_in <= c;
		@(posedge clock_in);
		wb_exc_in <= 1'b0;
		#1;
		chk(wb_fault_out, e);
	endtask

	task automatic t_reset;
		#1;
		chk({conv_fault_out, wb_fault_out, post_flag_out}, 3'h0);
		chk(frame_words_out, `FES_FRAME_BUSY);
		rd(`FES_OFF_STATUS);
		chk(rv[7:0], `FES_FRAME_BUSY);
		rd(8'h3c);
		chk(rv, 32'h0);
	endtask

	// sqrt in class 0: remap and readback of the command, pc, address and some operand words
	task automatic t_unimp;
		cap(2'h0, 16'h0004, 1'b0);
		chk({conv_fault_out, post_flag_out}, 2'b10);
		chk(frame_words_out, `FES_FRAME_UNIMP);
		rd(`FES_OFF_CMD);
		chk(rv[15:0], 16'h0005);
		chk({rv[30:28], rv[27], rv[25]}, 5'b000_01);
		@(posedge clock_in);
		#1 chk(rdata_out, 32'h0);
		rd(`FES_OFF_PC);
		chk(rv, 32'h0000_1230);
		rd(`FES_OFF_IAR);
		chk(rv, 32'h0000_1228);
		rd(`FES_OFF_SRC_HI);
		chk(rv, {SRC[79:64], 10'h0, 3'h1, 3'h4});
		rd(`FES_OFF_SRC_ML);
		chk(rv, SRC[31:0]);
		rd(`FES_OFF_DST_HI);
		chk(rv[31:16], DST[79:64]);
		rd(`FES_OFF_DST_MH);
		chk(rv, DST[63:32]);
	endtask

	task automatic t_packed;
		wr(`FES_OFF_CTRL, 32'h4);
		cap(2'h0, 16'h4022, 1'b1);
		chk(conv_fault_out, 1'b1);
		rd(`FES_OFF_CMD);
		chk({rv[30:28], rv[15:0]}, {3'h2, 16'h4022});
		rd(`FES_OFF_SRC_MH);
		chk(rv, PKD[63:32]);
		rd(`FES_OFF_SRC_ML);
		chk(rv, PKD[31:0]);
		rd(`FES_OFF_DST_ML);
		chk(rv, PKD[95:64]);
		rd(`FES_OFF_STATUS);
		chk(rv[9:8], 2'b11);
	endtask

	// unsupported and signaling nan, in class 0 and class 3
	task automatic t_kinds;
		logic three;
		for (int k = 1; k <= 2; k++) begin
			for (int i = 0; i < 2; i++) begin
				three = (i == 1);
				wr(`FES_OFF_CTRL, 32'h4);
				cap(k[1:0], three ? 16'h6800 : 16'h0022, 1'b0);
				chk({conv_fault_out, post_flag_out}, {1'b1, three});
				chk(frame_words_out, `FES_FRAME_BUSY);
				rd(`FES_OFF_SRC_MH);
				chk(rv, (three && k == 2) ? 32'hc123_4567 : SRC[63:32]);
				rd(`FES_OFF_SRC_HI);
				chk(rv[2:0], (three && k == 2) ? `FES_TAG_NAN : 3'h4);
			end
		end
		wr(`FES_OFF_CTRL, 32'h2);
		#1 chk({conv_fault_out, post_flag_out}, 2'b00);
	endtask

	// both stages fault beside a clear: set wins, write-back serviced first
	task automatic t_both;
		wr(`FES_OFF_CTRL, 32'h4);
		@(posedge clock_in);
		cu_exc_in <= 1'b1;
		cu_kind_in <= 2'h3;
		cu_cmd_in <= 16'h0022;
		wb_exc_in <= 1'b1;
		wb_kind_in <= 2'h1;
		wb_cmd_in <= 16'h0023;
		wr_in <= 1'b1;
		wdata_in <= 32'h3;
		@(posedge clock_in);
		cu_exc_in <= 1'b0;
		wb_exc_in <= 1'b0;
		wr_in <= 1'b0;
		#1 chk({conv_fault_out, wb_fault_out, post_flag_out}, 3'h6);
		chk(frame_words_out, `FES_FRAME_BUSY);
		rd(`FES_OFF_CMD);
		chk(rv[26:25], 2'b11);
		wr(`FES_OFF_CTRL, 32'h1);
		#1 chk({wb_fault_out, conv_fault_out}, 2'b01);
		wr(`FES_OFF_CTRL, 32'h2);
		#1 chk({conv_fault_out, post_flag_out}, 2'b00);
		// no destination operand: the temp keeps its earlier value
		dyadic_in <= 1'b0;
		dst_ext_in <= ~DST;
		cap(2'h0, 16'h0023, 1'b0);
		dyadic_in <= 1'b1;
		dst_ext_in <= DST;
		rd(`FES_OFF_DST_MH);
		chk(rv, DST[63:32]);
		chk(frame_words_out, `FES_FRAME_UNIMP);
		// reset in mid-run drops the frame back to its idle values
		@(posedge clock_in);
		nrst_in <= 1'b0;
		@(posedge clock_in);
		nrst_in <= 1'b1;
		#1 chk({conv_fault_out, wb_fault_out, post_flag_out}, 3'h0);
		chk(frame_words_out, `FES_FRAME_BUSY);
	endtask

	task automatic t_wb;
		wbone(2'h1, 16'h0004, 1'b1);
		rd(`FES_OFF_CMD);
		chk(rv[21:16], `FES_WB_SQRT_CODE);
		chk(rv[26], 1'b1);
		rd(`FES_OFF_WB_HI);
		chk(rv, {1'b1, 9'h0, 2'h1, 1'b1, WBM[0], WBM[1], WBM[66], 16'h8123});
		rd(`FES_OFF_WB_MH);
		chk(rv, WBM[65:34]);
		rd(`FES_OFF_WB_ML);
		chk(rv, WBM[33:2]);
		wbone(2'h2, 16'h4022, 1'b1);
		rd(`FES_OFF_CMD);
		chk(rv[21:16], 6'h0a);
		wbone(2'h3, 16'h0023, 1'b1);
		wbone(2'h2, 16'h0028, 1'b1);
		wbone(2'h3, 16'h4020, 1'b1);
		wbone(2'h0, 16'h0004, 1'b0);
		wbone(2'h1, 16'h6004, 1'b0);
		wbone(2'h1, 16'h0001, 1'b0);
	endtask

	initial begin
		repeat (12) @(posedge clock_in);
		nrst_in <= 1'b1;
		t_reset();
		t_unimp();
		t_packed();
		t_kinds();
		t_both();
		t_wb();
		final_report();
	end
endmodule
